// [i2c_slave_serial_port.sv]
// Two-wire slave logic of the synchronous serial port with APB registers.
// Assumes external pull-ups on both lines and an APB master on pclk.
//
// Implementation choice: register access over APB.
`timescale 1ns/1ps
module i2c_slave_serial_port (
    input wire logic pclk,
    input wire logic presetn,
    input wire i2c_port_pkg::apb_req_s apb_req,
    output i2c_port_pkg::apb_rsp_s apb_rsp,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic scl_out,
    output logic scl_oe,
    output logic sda_out,
    output logic sda_oe
);
    typedef struct packed {
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
        logic [7:0] ctl;
        logic [7:0] st;
        logic [7:0] flg;
        logic [7:0] ena;
        logic [7:0] addr;
        logic [7:0] xbuf;
        logic [1:0] dir;
        logic [7:0] sr;
        logic [3:0] cnt;
        i2c_port_pkg::phase_e ph;
        logic lo;
        logic hi_ok;
        logic ua_pend;
        logic tx;
        logic ack;
        logic hold;
        logic scl_p;
        logic sda_p;
        logic scl_oe;
        logic sda_oe;
        logic [8:0] baud;
        logic mclk;
    } dev_s;

    dev_s q;
    dev_s n;
    logic scl_f;
    logic sda_f;

    // =========================================================
    // Input conditioning
    // Same filter length serves both bus speeds
    glitch_filter #(
        .CYC(i2c_port_pkg::FILTER_CYC)
    ) u_scl_filter (
        .pclk(pclk),
        .presetn(presetn),
        .din(scl_in),
        .dout(scl_f)
    );

    glitch_filter #(
        .CYC(i2c_port_pkg::FILTER_CYC)
    ) u_sda_filter (
        .pclk(pclk),
        .presetn(presetn),
        .din(sda_in),
        .dout(sda_f)
    );

    // =========================================================
    // Next-state logic
    logic access;
    logic wr;
    logic rd;
    logic [9:0] idx;
    logic [9:0] sidx;
    logic [7:0] wd;
    logic rise;
    logic fall;
    logic start;
    logic stop;
    logic en;
    logic [3:0] mode;
    logic slv;
    logic ten;
    logic sp_irq;
    logic match;
    logic bf;
    logic ov;

    always_comb begin
        n = q;
        idx = apb_req.paddr[11:2];
        sidx = apb_req.paddr[11:2];
        wd = apb_req.pwdata[7:0];
        access = apb_req.psel & apb_req.penable & q.pready;
        // An access answered with an error changes nothing
        wr = access & apb_req.pwrite & ~q.pslverr;
        rd = access & ~apb_req.pwrite & ~q.pslverr;
        match = 1'b0;
        bf = q.st[i2c_port_pkg::ST_BF];
        ov = q.ctl[i2c_port_pkg::CTL_OV];

        // Answer one cycle after setup; data captured at setup
        n.pready = apb_req.psel & ~apb_req.penable;
        n.pslverr = 1'b0;
        n.prdata = '0;
        if (apb_req.psel & ~apb_req.penable) begin
            if (apb_req.paddr[1:0] != 2'h0) begin
                n.pslverr = 1'b1;
            end else if (sidx == i2c_port_pkg::IDX_FLAGS) begin
                n.prdata[7:0] = q.flg;
            end else if (sidx == i2c_port_pkg::IDX_XBUF) begin
                n.prdata[7:0] = q.xbuf;
            end else if (sidx == i2c_port_pkg::IDX_CTL) begin
                n.prdata[7:0] = q.ctl;
            end else if (sidx == i2c_port_pkg::IDX_ENA) begin
                n.prdata[7:0] = q.ena;
            end else if (sidx == i2c_port_pkg::IDX_STAT) begin
                n.prdata[7:0] = q.st;
            end else if (sidx == i2c_port_pkg::IDX_ADDR) begin
                n.prdata[7:0] = q.addr;
            end else if (sidx == i2c_port_pkg::IDX_DIR) begin
                n.prdata[1:0] = q.dir;
            end else begin
                n.pslverr = 1'b1;
            end
        end

        // Software writes first, so hardware sets below win
        if (wr) begin
            if (idx == i2c_port_pkg::IDX_FLAGS) begin
                n.flg = wd & i2c_port_pkg::FLG_MASK;
            end else if (idx == i2c_port_pkg::IDX_XBUF) begin
                n.xbuf = wd;
            end else if (idx == i2c_port_pkg::IDX_CTL) begin
                n.ctl = wd;
                if (wd[i2c_port_pkg::CTL_CKP] && q.tx) begin
                    n.hold = 1'b0;
                end
            end else if (idx == i2c_port_pkg::IDX_ENA) begin
                n.ena = wd & i2c_port_pkg::FLG_MASK;
            end else if (idx == i2c_port_pkg::IDX_STAT) begin
                n.st = (q.st & ~i2c_port_pkg::ST_WR_MASK)
                     | (wd & i2c_port_pkg::ST_WR_MASK);
            end else if (idx == i2c_port_pkg::IDX_ADDR) begin
                n.addr = wd;
                n.st[i2c_port_pkg::ST_UA] = 1'b0;
                if (q.st[i2c_port_pkg::ST_UA]) begin
                    n.hold = 1'b0;
                end
            end else if (idx == i2c_port_pkg::IDX_DIR) begin
                n.dir = wd[1:0];
            end
        end
        if (rd && idx == i2c_port_pkg::IDX_XBUF) begin
            n.st[i2c_port_pkg::ST_BF] = 1'b0;
        end

        // Bus events from filtered lines
        n.scl_p = scl_f;
        n.sda_p = sda_f;
        rise = scl_f & ~q.scl_p;
        fall = ~scl_f & q.scl_p;
        start = q.scl_p & scl_f & q.sda_p & ~sda_f;
        stop = q.scl_p & scl_f & ~q.sda_p & sda_f;

        en = q.ctl[i2c_port_pkg::CTL_EN];
        mode = q.ctl[3:0];
        slv = (mode == i2c_port_pkg::MODE_SLV7) || (mode == i2c_port_pkg::MODE_SLV10)
            || (mode == i2c_port_pkg::MODE_SLV7_SP) || (mode == i2c_port_pkg::MODE_SLV10_SP);
        ten = (mode == i2c_port_pkg::MODE_SLV10) || (mode == i2c_port_pkg::MODE_SLV10_SP);
        sp_irq = (mode == i2c_port_pkg::MODE_SLV7_SP) || (mode == i2c_port_pkg::MODE_SLV10_SP)
            || (mode == i2c_port_pkg::MODE_FWMASTER);

        if (!en) begin
            // Disabled port forgets the transfer and lets go of the bus
            n.ph = i2c_port_pkg::PH_IDLE;
            n.hold = 1'b0;
            n.ack = 1'b0;
            n.tx = 1'b0;
            n.lo = 1'b0;
            n.hi_ok = 1'b0;
            n.ua_pend = 1'b0;
            n.st[i2c_port_pkg::ST_S] = 1'b0;
            n.st[i2c_port_pkg::ST_P] = 1'b0;
            n.mclk = 1'b1;
            n.baud = '0;
        end else begin
            // Start and stop tracking for every mode
            if (start) begin
                n.st[i2c_port_pkg::ST_S] = 1'b1;
                n.st[i2c_port_pkg::ST_P] = 1'b0;
                if (sp_irq) begin
                    n.flg[i2c_port_pkg::FLG_PORT] = 1'b1;
                end
            end
            if (stop) begin
                n.st[i2c_port_pkg::ST_P] = 1'b1;
                n.st[i2c_port_pkg::ST_S] = 1'b0;
                if (sp_irq) begin
                    n.flg[i2c_port_pkg::FLG_PORT] = 1'b1;
                end
            end

            if (slv) begin
                case (q.ph)
                    i2c_port_pkg::PH_ADDR, i2c_port_pkg::PH_DATA: begin
                        if (rise) begin
                            n.sr = {q.sr[6:0], sda_f};
                            n.cnt = q.cnt + 4'h1;
                        end
                        if (fall && q.cnt == i2c_port_pkg::BITS_PER_BYTE) begin
                            n.ua_pend = 1'b0;
                            if (q.ph == i2c_port_pkg::PH_DATA) begin
                                match = 1'b1;
                            end else if (!ten) begin
                                match = q.sr[7:1] == q.addr[7:1];
                            end else if (q.lo) begin
                                // Low byte of a ten-bit address uses all bits
                                match = q.sr == q.addr;
                                n.ua_pend = match;
                                n.hi_ok = match;
                                n.lo = 1'b0;
                            end else if (q.sr[7:3] == i2c_port_pkg::TEN_BIT_HDR) begin
                                // High byte, direction excluded from compare
                                match = q.sr[7:1] == q.addr[7:1];
                                if (q.sr[0]) begin
                                    match = match & q.hi_ok;
                                end else begin
                                    n.lo = match;
                                    n.ua_pend = match;
                                end
                            end
                            if (match) begin
                                if (bf) begin
                                    n.ctl[i2c_port_pkg::CTL_OV] = 1'b1;
                                end else begin
                                    n.xbuf = q.sr;
                                    n.st[i2c_port_pkg::ST_BF] = 1'b1;
                                end
                                n.ack = ~bf & ~ov;
                                n.st[i2c_port_pkg::ST_DA] = q.ph == i2c_port_pkg::PH_DATA;
                                if (q.ph == i2c_port_pkg::PH_ADDR) begin
                                    n.st[i2c_port_pkg::ST_RW] = q.sr[0];
                                    n.tx = q.sr[0];
                                end
                                n.ph = i2c_port_pkg::PH_ACK;
                            end else begin
                                n.ph = i2c_port_pkg::PH_IDLE;
                            end
                            n.cnt = '0;
                        end
                    end
                    i2c_port_pkg::PH_ACK: begin
                        if (fall) begin
                            n.flg[i2c_port_pkg::FLG_PORT] = 1'b1;
                            n.ack = 1'b0;
                            if (q.ua_pend) begin
                                n.st[i2c_port_pkg::ST_UA] = 1'b1;
                                n.hold = 1'b1;
                            end
                            if (q.tx) begin
                                // Stretch until software readies transmit data
                                n.hold = 1'b1;
                                n.ctl[i2c_port_pkg::CTL_CKP] = 1'b0;
                                n.ph = i2c_port_pkg::PH_IDLE;
                            end else if (q.lo) begin
                                n.ph = i2c_port_pkg::PH_ADDR;
                            end else begin
                                n.ph = i2c_port_pkg::PH_DATA;
                            end
                        end
                    end
                    default: begin
                    end
                endcase
                if (start) begin
                    n.ph = i2c_port_pkg::PH_ADDR;
                    n.cnt = '0;
                    n.lo = 1'b0;
                    n.ack = 1'b0;
                    n.tx = 1'b0;
                end
                if (stop) begin
                    n.ph = i2c_port_pkg::PH_IDLE;
                    n.hi_ok = 1'b0;
                    n.lo = 1'b0;
                    n.ack = 1'b0;
                    n.tx = 1'b0;
                end
            end else begin
                n.ph = i2c_port_pkg::PH_IDLE;
                n.ack = 1'b0;
                n.hold = 1'b0;
            end

            // Bus clock generator: half period is 2*(addr+1) cycles
            if (mode == i2c_port_pkg::MODE_MASTER) begin
                if (q.baud == '0) begin
                    n.baud = {q.addr, 1'b1};
                    n.mclk = ~q.mclk;
                end else begin
                    n.baud = q.baud - 9'h001;
                end
            end else begin
                n.mclk = 1'b1;
                n.baud = '0;
            end
        end

        // Open-drain drive: only a low is ever driven
        if (!en) begin
            n.scl_oe = 1'b0;
            n.sda_oe = 1'b0;
        end else if (mode == i2c_port_pkg::MODE_FWMASTER) begin
            n.scl_oe = ~q.dir[i2c_port_pkg::DIR_SCL];
            n.sda_oe = ~q.dir[i2c_port_pkg::DIR_SDA];
        end else if (mode == i2c_port_pkg::MODE_MASTER) begin
            n.scl_oe = ~n.mclk;
            n.sda_oe = 1'b0;
        end else begin
            n.scl_oe = n.hold;
            n.sda_oe = n.ack;
        end
    end

    // =========================================================
    // State register; reset drops the port and any transfer
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q <= '0;
            q.ctl <= i2c_port_pkg::CTL_RST;
            q.st <= i2c_port_pkg::ST_RST;
            q.flg <= i2c_port_pkg::FLG_RST;
            q.ena <= i2c_port_pkg::ENA_RST;
            q.addr <= i2c_port_pkg::ADDR_RST;
            q.dir <= i2c_port_pkg::DIR_RST;
            q.scl_p <= 1'b1;
            q.sda_p <= 1'b1;
            q.mclk <= 1'b1;
        end else begin
            q <= n;
        end
    end

    // =========================================================
    // Outputs straight from the state register
    assign apb_rsp.pready = q.pready;
    assign apb_rsp.pslverr = q.pslverr;
    assign apb_rsp.prdata = q.prdata;
    assign scl_oe = q.scl_oe;
    assign sda_oe = q.sda_oe;
    // Both output values are always low, enabled or not; pull-ups give the high level
    assign scl_out = 1'b0;
    assign sda_out = 1'b0;
endmodule

// [i2c_port_pkg.sv]
// Constants, types and carriers shared by the serial port files.
// Assumes a 200 MHz pclk and an APB master with 32-bit data.
package i2c_port_pkg;

    // =========================================================
    // Register indices (byte address is four times the index)
    localparam logic [9:0] IDX_FLAGS = 10'h00c;
    localparam logic [9:0] IDX_XBUF = 10'h013;
    localparam logic [9:0] IDX_CTL = 10'h014;
    localparam logic [9:0] IDX_ENA = 10'h08c;
    localparam logic [9:0] IDX_STAT = 10'h094;
    localparam logic [9:0] IDX_ADDR = 10'h093;
    localparam logic [9:0] IDX_DIR = 10'h087;

    // =========================================================
    // Field positions
    localparam int CTL_WRITE_COLLISION_FLAG = 7;
    localparam int CTL_OV = 6;
    localparam int CTL_EN = 5;
    localparam int CTL_CKP = 4;
    localparam int ST_DA = 5;
    localparam int ST_P = 4;
    localparam int ST_S = 3;
    localparam int ST_RW = 2;
    localparam int ST_UA = 1;
    localparam int ST_BF = 0;
    localparam int FLG_PORT = 3;
    localparam int DIR_SCL = 0;
    localparam int DIR_SDA = 1;
    localparam logic [7:0] FLG_MASK = 8'h4f;
    localparam logic [7:0] ST_WR_MASK = 8'hc0;

    // =========================================================
    // Reset values
    localparam logic [7:0] CTL_RST = 8'h00;
    localparam logic [7:0] ST_RST = 8'h00;
    localparam logic [7:0] FLG_RST = 8'h00;
    localparam logic [7:0] ENA_RST = 8'h00;
    localparam logic [7:0] ADDR_RST = 8'h00;
    localparam logic [1:0] DIR_RST = 2'h3;

    // =========================================================
    // Modes, address pattern and timing
    typedef enum logic [3:0] {
        MODE_SLV7 = 4'h6,
        MODE_SLV10 = 4'h7,
        MODE_MASTER = 4'h8,
        MODE_FWMASTER = 4'hb,
        MODE_SLV7_SP = 4'he,
        MODE_SLV10_SP = 4'hf
    } mode_e;
    localparam logic [4:0] TEN_BIT_HDR = 5'h1e;
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;
    localparam int CLK_MHZ = 200;
    localparam int FILTER_NS = 50;
    localparam int FILTER_CYC = (FILTER_NS * CLK_MHZ + 999) / 1000;

    typedef enum logic [2:0] {
        PH_IDLE = 3'h0,
        PH_ADDR = 3'h1,
        PH_ACK = 3'h2,
        PH_DATA = 3'h3
    } phase_e;

    // =========================================================
    // APB carriers
    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } apb_req_s;

    typedef struct packed {
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } apb_rsp_s;

endpackage

// [glitch_filter.sv]
// Two-flop synchroniser followed by a stability filter for one pin.
// Assumes the pin idles high; output changes only after a stable run.
`timescale 1ns/1ps
module glitch_filter #(
    parameter int CYC = 10
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic din,
    output logic dout
);
    localparam int CW = $clog2(CYC + 1);

    typedef struct packed {
        logic s1;
        logic s2;
        logic level;
        logic [CW-1:0] cnt;
    } flt_s;

    flt_s q;
    flt_s n;

    // =========================================================
    // Filter: a pulse shorter than CYC cycles never reaches dout
    always_comb begin
        n = q;
        n.s1 = din;
        n.s2 = q.s1;
        if (q.s2 == q.level) begin
            n.cnt = '0;
        end else if (q.cnt == CW'(CYC - 1)) begin
            n.level = q.s2;
            n.cnt = '0;
        end else begin
            n.cnt = q.cnt + CW'(1);
        end
    end

    // Idle-high reset avoids a false edge after release
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q <= '{s1: 1'b1, s2: 1'b1, level: 1'b1, cnt: '0};
        end else begin
            q <= n;
        end
    end

    assign dout = q.level;
endmodule

// [i2c_port_properties.sv]
// Port checker for the two-wire serial port, bound into its top module.
// Assumes one pclk domain; control state is mirrored from completed writes.
`timescale 1ns/1ps
module i2c_port_properties (
    input wire logic pclk,
    input wire logic presetn,
    input wire i2c_port_pkg::apb_req_s apb_req,
    input wire i2c_port_pkg::apb_rsp_s apb_rsp,
    input wire logic scl_out,
    input wire logic scl_oe,
    input wire logic sda_out,
    input wire logic sda_oe
);
    // ==========================================================
    // Mirrors of written control state
    logic wr;
    logic en_q;
    logic [3:0] mode_q;
    logic [1:0] dir_q;
    logic [2:0] quiet_q;
    assign wr = apb_req.psel && apb_req.penable && apb_rsp.pready && apb_req.pwrite
        && !apb_rsp.pslverr;
    // Outputs lag a write, so checks wait
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            en_q <= 1'b0;
            mode_q <= 4'h0;
            dir_q <= 2'h3;
            quiet_q <= 3'h0;
        end else begin
            quiet_q <= wr ? 3'h0 : quiet_q + {2'h0, quiet_q != 3'h7};
            if (wr && apb_req.paddr[11:2] == i2c_port_pkg::IDX_CTL) begin
                en_q <= apb_req.pwdata[i2c_port_pkg::CTL_EN];
                mode_q <= apb_req.pwdata[3:0];
            end
            if (wr && apb_req.paddr[11:2] == i2c_port_pkg::IDX_DIR)
                dir_q <= apb_req.pwdata[1:0];
        end
    end

    // ==========================================================
    // Properties
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    a_ready_after_setup: assert property (apb_req.psel && !apb_req.penable |=> apb_rsp.pready)
        else $error("no pready after setup");
    a_ready_one_cycle: assert property (apb_rsp.pready |=> !apb_rsp.pready)
        else $error("pready held");
    a_error_in_access: assert property (apb_rsp.pslverr |-> apb_rsp.pready && apb_req.penable)
        else $error("pslverr outside access");
    a_misaligned_error: assert property (apb_rsp.pready && apb_req.paddr[1:0] != 2'h0
        |-> apb_rsp.pslverr) else $error("misaligned access taken");
    a_lines_low_only: assert property (!scl_out && !sda_out)
        else $error("line driven high");
    a_idle_when_off: assert property (!en_q && quiet_q == 3'h7 |-> !scl_oe && !sda_oe)
        else $error("line pulled while disabled");
    a_fw_pins_follow: assert property (en_q && mode_q == 4'hb && quiet_q == 3'h7
        |-> scl_oe == !dir_q[0] && sda_oe == !dir_q[1]) else $error("pins ignore directions");
    a_hold_until_write: assert property ($fell(scl_oe) && mode_q != 4'h8
        |-> quiet_q != 3'h7) else $error("clock hold ended without write");
endmodule

bind i2c_slave_serial_port i2c_port_properties chk (.pclk, .presetn, .apb_req, .apb_rsp,
    .scl_out, .scl_oe, .sda_out, .sda_oe);

// [i2c_master_model.sv]
// Bus master model that pulls the two-wire lines low or releases them.
// Assumes pull-ups on the resolved wires: a released line reads high.
`timescale 1ns/1ps
module i2c_master_model (
    input wire logic pclk,
    input wire logic scl,
    input wire logic sda,
    output logic scl_low,
    output logic sda_low
);
    // ==========================================================
    // Half bit time in pclk cycles, well above the slave's filter delay
    int hp = 40;
    initial {scl_low, sda_low} = 2'b00;
    task automatic wt(input int n);
        repeat (n) @(posedge pclk);
    endtask
    // Release SCL, give way while the slave stretches it, then hold high
    task automatic rise();
        int n = 0;
        scl_low <= 1'b0;
        do @(posedge pclk); while (!scl && n++ < 5000);
        wt(hp);
    endtask
    task automatic bit_io(input logic b, output logic r);
        sda_low <= !b;
        wt(hp);
        rise();
        r = sda;
        scl_low <= 1'b1;
        wt(hp);
    endtask
    task automatic start();
        sda_low <= 1'b0;
        wt(hp);
        rise();
        sda_low <= 1'b1;
        wt(hp);
        scl_low <= 1'b1;
        wt(hp);
    endtask
    task automatic stop();
        sda_low <= 1'b1;
        wt(hp);
        rise();
        sda_low <= 1'b0;
        wt(hp);
    endtask
    // Byte MSB first, then the acknowledge slot with SDA released
    task automatic xfer(input logic [7:0] b, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--)
            bit_io(b[i], r);
        bit_io(1'b1, r);
        ack = !r;
    endtask
endmodule

// [i2c_slave_serial_port_test.sv]
// Self-checking bench: APB tasks, a bus master model and port checks.
// Assumes the package, design, checker and master model compile first.
`timescale 1ns/1ps
`define CHK(a, x) begin comparisons++; if ((a) !== (x)) begin mismatches++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (a), (x)); end end
module i2c_slave_serial_port_test;
    localparam FLG = i2c_port_pkg::IDX_FLAGS;
    localparam XB = i2c_port_pkg::IDX_XBUF;
    localparam CTL = i2c_port_pkg::IDX_CTL;
    localparam STA = i2c_port_pkg::IDX_STAT;
    localparam ADR = i2c_port_pkg::IDX_ADDR;
    localparam DIR = i2c_port_pkg::IDX_DIR;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic glitch = 1'b0;
    logic scl, sda, scl_low, sda_low, scl_oe, sda_oe, e, ack;
    i2c_port_pkg::apb_req_s req = '0;
    i2c_port_pkg::apb_rsp_s rsp;
    i2c_port_pkg::mode_e md;
    int mismatches = 0;
    int comparisons = 0;
    int n, k;
    logic [7:0] rd, a7, d, hi, lo;

    // ==========================================================
    // Clock, wired-AND lines with pull-ups, design and master
    always #2.5 pclk = ~pclk;
    assign scl = !(scl_low || scl_oe);
    assign sda = !(sda_low || sda_oe || glitch);
    i2c_slave_serial_port uut (.pclk, .presetn, .apb_req(req), .apb_rsp(rsp), .scl_in(scl),
        .sda_in(sda), .scl_out(), .scl_oe, .sda_out(), .sda_oe);
    i2c_master_model m (.pclk, .scl, .sda, .scl_low, .sda_low);

    // ==========================================================
    // APB transfer: request held until pready is sampled high
    task automatic apb(input logic w, input logic [9:0] idx, input logic [7:0] wd,
        input logic [1:0] off = 2'h0);
        int c = 0;
        @(posedge pclk);
        req <= '{1'b1, 1'b0, w, {idx, off}, {24'h0, wd}};
        @(posedge pclk);
        req.penable <= 1'b1;
        do @(posedge pclk); while (rsp.pready !== 1'b1 && c++ < 50);
        rd = rsp.prdata[7:0];
        e = rsp.pslverr;
        req <= '0;
    endtask
    task automatic wr(input logic [9:0] idx, input logic [7:0] wd);
        apb(1'b1, idx, wd);
    endtask
    task automatic rchk(input logic [9:0] idx, input logic [7:0] x,
        input logic [7:0] msk = 8'hff);
        apb(1'b0, idx, 8'h00);
        `CHK(rd & msk, x)
    endtask
    // Cycles until the clock drive changes level
    task automatic gap(output int c);
        logic v;
        v = scl_oe;
        c = 0;
        while (scl_oe === v && c < 99) begin
            @(posedge pclk);
            c++;
        end
    endtask
    // Enable in a mode with the clock released; send a byte, check the answer
    task automatic on(input logic [3:0] mode);
        wr(CTL, {4'h3, mode});
    endtask
    task automatic xa(input logic [7:0] b, input logic x);
        m.xfer(b, ack);
        `CHK(ack, x)
    endtask
    task automatic conclude();
        $display("comparisons=%0d mismatches=%0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    // Watchdog, well past the expected 12300 cycles
    initial begin
        repeat (90000) @(posedge pclk);
        mismatches++;
        conclude();
    end

    // ==========================================================
    // Main sequence
    initial begin
        void'($urandom(32'hf0c8));
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        rchk(CTL, i2c_port_pkg::CTL_RST);
        rchk(STA, i2c_port_pkg::ST_RST);
        rchk(DIR, i2c_port_pkg::DIR_RST, 8'h03);
        apb(1'b0, 10'h3ff, 8'h00);
        `CHK(e, 1'b1)
        apb(1'b1, CTL, 8'hff, 2'h2);
        `CHK(e, 1'b1)
        rchk(CTL, 8'h00);
        md = md.first();
        repeat (md.num()) begin
            wr(CTL, {4'h0, md});
            rchk(CTL, {4'h0, md});
            md = md.next();
        end
        // Seven-bit write: address, a byte against a full buffer, then bytes with overflow set and cleared
        a7 = {7'($urandom_range(8, 119)), 1'b0};
        wr(ADR, a7);
        on(i2c_port_pkg::MODE_SLV7);
        m.start();
        xa(a7, 1'b1);
        rchk(STA, 8'h01, 8'h05);
        rchk(FLG, 8'h08, 8'h08);
        xa(8'($urandom), 1'b0);
        rchk(CTL, 8'h40, 8'h40);
        rchk(XB, a7);
        rchk(STA, 8'h00, 8'h01);
        rchk(CTL, 8'h40, 8'h40);
        d = 8'($urandom);
        xa(d, 1'b0);
        rchk(XB, d);
        on(i2c_port_pkg::MODE_SLV7);
        wr(FLG, 8'h00);
        d = 8'($urandom);
        xa(d, 1'b1);
        rchk(FLG, 8'h08, 8'h08);
        rchk(XB, d);
        // Wrong address, then the direction bit left out of the match
        m.start();
        xa(a7 ^ (8'h01 << $urandom_range(1, 7)), 1'b0);
        m.start();
        xa(a7 | 8'h01, 1'b1);
        on(i2c_port_pkg::MODE_SLV7);
        rchk(XB, a7 | 8'h01);
        m.stop();
        wr(CTL, {4'h1, i2c_port_pkg::MODE_SLV7});
        m.start();
        xa(a7, 1'b0);
        m.stop();
        // Start and stop flags; a short pulse on SDA must not count
        on(i2c_port_pkg::MODE_SLV7_SP);
        wr(FLG, 8'h00);
        glitch <= 1'b1;
        repeat (3) @(posedge pclk);
        glitch <= 1'b0;
        repeat (30) @(posedge pclk);
        rchk(FLG, 8'h00, 8'h08);
        m.start();
        rchk(FLG, 8'h08, 8'h08);
        wr(FLG, 8'h00);
        m.stop();
        rchk(FLG, 8'h08, 8'h08);
        // Ten-bit write then repeated start for reading, faster master
        hi = {5'h1e, 2'($urandom), 1'b0};
        lo = 8'($urandom);
        m.hp = 25;
        wr(ADR, hi);
        on(i2c_port_pkg::MODE_SLV10_SP);
        m.start();
        xa(hi, 1'b1);
        rchk(STA, 8'h03, 8'h03);
        `CHK(scl_oe, 1'b1)
        wr(ADR, lo);
        rchk(STA, 8'h00, 8'h02);
        `CHK(scl_oe, 1'b0)
        rchk(XB, hi);
        xa(lo, 1'b1);
        rchk(STA, 8'h03, 8'h03);
        wr(ADR, hi);
        rchk(XB, lo);
        m.start();
        xa(hi | 8'h01, 1'b1);
        rchk(STA, 8'h04, 8'h04);
        on(i2c_port_pkg::MODE_SLV10_SP);
        rchk(XB, hi | 8'h01);
        m.stop();
        // Firmware-driven pins, then the generated clock rate
        on(i2c_port_pkg::MODE_FWMASTER);
        wr(FLG, 8'h00);
        wr(DIR, 8'h01);
        repeat (20) @(posedge pclk);
        `CHK({scl_oe, sda_oe}, 2'b01)
        rchk(FLG, 8'h08, 8'h08);
        wr(DIR, 8'h03);
        repeat (20) @(posedge pclk);
        `CHK({scl_oe, sda_oe}, 2'b00)
        n = $urandom_range(1, 4);
        wr(ADR, 8'(n));
        on(i2c_port_pkg::MODE_MASTER);
        gap(k);
        gap(k);
        `CHK(k, 2 * (n + 1))
        // Reset in mid-byte abandons the transfer
        wr(ADR, a7);
        on(i2c_port_pkg::MODE_SLV7);
        m.start();
        fork
            m.xfer(a7, ack);
            begin
                repeat (300) @(posedge pclk);
                presetn <= 1'b0;
                repeat (2) @(posedge pclk);
                presetn <= 1'b1;
            end
        join
        `CHK({scl_oe, sda_oe}, 2'b00)
        rchk(CTL, 8'h00);
        m.stop();
        conclude();
    end
endmodule
